/* sfm_buf2.v */
// two-entry valid/ready buffer between the write port and the memory array
`include "sfm_defs.vh"
module sfm_buf2 (
  input wire clk_sys, // system clock
  input wire rst_b, // async reset, active low
  input wire clear, // synchronous flush
  input wire in_valid, // word offered
  output wire in_ready, // room for a word
  input wire [`SFM_WIDTH-1:0] in_data, // word in
  output wire out_valid, // word available
  input wire out_ready, // sink takes word
  output wire [`SFM_WIDTH-1:0] out_data // oldest word
);

reg [`SFM_WIDTH-1:0] slot0;
reg [`SFM_WIDTH-1:0] slot1;
reg [1:0] level;
wire push;
wire pop;

assign in_ready = (level != 2'h2);
assign out_valid = (level != 2'h0);
assign out_data = slot0;
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    slot0 <= {`SFM_WIDTH{1'b0}};
    slot1 <= {`SFM_WIDTH{1'b0}};
    level <= 2'h0;
  end else if (clear) begin
    level <= 2'h0;
  end else begin
    if (pop) begin
      slot0 <= (level == 2'h2) ? slot1 : in_data;
    end else if (push && level == 2'h0) begin
      slot0 <= in_data;
    end
    if (push && ((level == 2'h1 && !pop) || level == 2'h2)) begin
      slot1 <= in_data;
    end
    case ({push, pop})
      2'b10: level <= level + 2'h1;
      2'b01: level <= level - 2'h1;
      default: level <= level;
    endcase
  end
end

endmodule // sfm_buf2

/* sfm_defs.vh */
// shared constants for the fifo bank: geometry, offsets, mode straps, link timing
`ifndef SFM_DEFS_VH
`define SFM_DEFS_VH

// geometry of one bank
`define SFM_WIDTH 18
`define SFM_AW 8
`define SFM_CW 9
`define SFM_DEPTH 9'h100
`define SFM_HALF 9'h080
`define SFM_CAP_STD 9'h100
`define SFM_CAP_FALL_THROUGH_MODE 9'h101

// offsets used when none has been programmed
`define SFM_OFS_W 12
`define SFM_DEF_EMPTY_OFS 12'h01F
`define SFM_DEF_FULL_OFS 12'h01F

// strap pattern {first_load_n, read_chain_in_n, write_chain_in_n} that selects fall-through
`define SFM_MODE_FALL_THROUGH_MODE 3'h2

// read-clock rising edges before the first word falls through
`define SFM_FALL_EDGES 2'h3

// link clock figures, informative for the bench
`define SFM_SYS_PERIOD_NS 25
`define SFM_LINK_PERIOD_NS 200
`define SFM_LINK_CYCLES (`SFM_LINK_PERIOD_NS / `SFM_SYS_PERIOD_NS)

// synchroniser width: 8 control pins plus the data word
`define SFM_SYNC_W (`SFM_WIDTH + 8)

`endif

/* sfm_far.sv */
// far-side producer and consumer model on the write and read ports
`include "sfm_defs.vh"
module sfm_far (
  input logic clk_sys, // system clock, requests change just after its rise
  output logic wr_clk = 1'b0, // write clock, free running
  output logic wr_en_n = 1'b1, // write enable, active low
  output logic [`SFM_WIDTH-1:0] wr_data = 18'h3FFFF, // write data
  output logic rd_clk = 1'b0, // read clock
  output logic rd_en_n = 1'b1 // read enable, active low
);
  timeunit 1ns;
  timeprecision 100ps;
  always #(`SFM_LINK_PERIOD_NS / 2) wr_clk = ~wr_clk;
  // read clock phase unrelated to the write clock
  initial begin
    #37;
    forever #(`SFM_LINK_PERIOD_NS / 2) rd_clk = ~rd_clk;
  end
  // change just after the system clock rise that follows a falling link edge,
  // so everything is settled around the sampled link rise
  task automatic op(input bit w, input bit r, input logic [`SFM_WIDTH-1:0] d);
    @(negedge wr_clk);
    @(posedge clk_sys);
    wr_en_n <= !w;
    wr_data <= d;
    rd_en_n <= !r;
    @(negedge wr_clk);
    @(posedge clk_sys);
    wr_en_n <= 1'b1;
    wr_data <= ~d; // idle bus never shows a stale copy
    rd_en_n <= 1'b1;
  endtask
endmodule // sfm_far

/* sfm_fifo.v */
// one fifo bank with standard and fall-through timing, sampled write and read clocks, status flags
`include "sfm_defs.vh"
module sfm_fifo (
  input wire clk_sys, // 40 MHz system clock
  input wire rst_b, // async reset, active low
  input wire reset_in_n, // bank reset pin, active low
  input wire first_load_n, // mode strap
  input wire read_chain_in_n, // mode strap
  input wire write_chain_in_n, // mode strap
  input wire wr_clk, // producer write clock
  input wire wr_en_n, // write enable, active low
  input wire [`SFM_WIDTH-1:0] wr_data, // write data
  input wire rd_clk, // consumer read clock
  input wire rd_en_n, // read enable, active low
  input wire [`SFM_OFS_W-1:0] empty_offset, // programmed empty offset
  input wire empty_offset_set, // use programmed empty offset
  input wire [`SFM_OFS_W-1:0] full_offset, // programmed full offset
  input wire full_offset_set, // use programmed full offset
  output reg [`SFM_WIDTH-1:0] data_out, // output data lines
  output reg empty_flag_n, // standard-mode empty, active low
  output reg full_flag_n, // standard-mode full, active low
  output reg half_full_flag_n, // half full, active low
  output reg almost_empty_flag_n, // almost empty, active low
  output reg almost_full_flag_n, // almost full, active low
  output reg input_ready_n, // fall-through input ready, active low
  output reg output_ready_n, // fall-through output ready, active low
  output reg fall_through_mode // selected mode, high for fall-through
);

// fall-through output stage states
localparam ST_EMPTY = 3'b001;
localparam ST_FALL = 3'b010;
localparam ST_HOLD = 3'b100;

// true when cnt has reached thr; widened so offsets larger than the depth cannot wrap
function reached;
  input [12:0] cnt;
  input [12:0] thr;
  begin
    reached = (cnt >= thr);
  end
endfunction

// rising edge of a sampled pin, seen against its value one cycle earlier
function rose_now;
  input cur;
  input prev;
  begin
    rose_now = cur & ~prev;
  end
endfunction

// output register holds a word that the reader may take
function holding;
  input [2:0] st;
  begin
    holding = (st == ST_HOLD);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: every pin passes two flops; data travels with its clock so both
// are seen in the same system cycle
wire [`SFM_SYNC_W-1:0] pin_raw;
wire [`SFM_SYNC_W-1:0] pin_sync;
reg wr_clk_last;
reg rd_clk_last;

assign pin_raw = {reset_in_n, first_load_n, read_chain_in_n, write_chain_in_n,
                  wr_clk, wr_en_n, rd_clk, rd_en_n, wr_data};

// one two-flop chain per pin; only the second flop of each chain is read
genvar gi;
generate
  for (gi = 0; gi < `SFM_SYNC_W; gi = gi + 1) begin : g_pin_sync
    reg meta;
    reg held;
    always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        meta <= 1'b1;
        held <= 1'b1;
      end else begin
        meta <= pin_raw[gi];
        held <= meta;
      end
    end
    assign pin_sync[gi] = held;
  end
endgenerate

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    wr_clk_last <= 1'b1;
    rd_clk_last <= 1'b1;
  end else begin
    wr_clk_last <= pin_sync[`SFM_WIDTH+3];
    rd_clk_last <= pin_sync[`SFM_WIDTH+1];
  end
end

wire s_reset_n = pin_sync[`SFM_WIDTH+7];
wire [2:0] s_straps = pin_sync[`SFM_WIDTH+6:`SFM_WIDTH+4];
wire s_wr_clk = pin_sync[`SFM_WIDTH+3];
wire s_wr_en_n = pin_sync[`SFM_WIDTH+2];
wire s_rd_clk = pin_sync[`SFM_WIDTH+1];
wire s_rd_en_n = pin_sync[`SFM_WIDTH];
wire [`SFM_WIDTH-1:0] s_wr_data = pin_sync[`SFM_WIDTH-1:0];
wire wr_rise = rose_now(s_wr_clk, wr_clk_last);
wire rd_rise = rose_now(s_rd_clk, rd_clk_last);

////////////////////////////////////////////////////////////////////////////////
// storage and occupancy
reg [`SFM_WIDTH-1:0] mem [0:(1<<`SFM_AW)-1];
reg [`SFM_AW-1:0] wptr;
reg [`SFM_AW-1:0] rptr;
reg [`SFM_CW-1:0] word_count;
reg [`SFM_CW-1:0] mem_count;
reg [2:0] out_state;
reg [1:0] edge_cnt;

wire [`SFM_CW-1:0] capacity = fall_through_mode ? `SFM_CAP_FALL_THROUGH_MODE : `SFM_CAP_STD;
wire mem_has_word = (mem_count != {`SFM_CW{1'b0}});

// write path through the two-entry buffer; a stalled buffer refuses the write
wire buf_in_ready;
wire buf_out_valid;
wire [`SFM_WIDTH-1:0] buf_out_data;
wire buf_out_ready = (mem_count < `SFM_DEPTH);
wire wr_offer = s_reset_n & wr_rise & ~s_wr_en_n & (word_count < capacity);
wire wr_take = wr_offer & buf_in_ready;
wire drain = buf_out_valid & buf_out_ready;

sfm_buf2 u_inbuf (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .clear(~s_reset_n),
  .in_valid(wr_offer),
  .in_ready(buf_in_ready),
  .in_data(s_wr_data),
  .out_valid(buf_out_valid),
  .out_ready(buf_out_ready),
  .out_data(buf_out_data)
);

// read requests; standard reads only when memory holds a word
wire rd_req = s_reset_n & rd_rise & ~s_rd_en_n;
wire std_take = ~fall_through_mode & rd_req & mem_has_word;
wire fall_through_mode_take = fall_through_mode & holding(out_state) & rd_req;
wire fall_through_mode_first = fall_through_mode & (out_state == ST_FALL) & rd_rise &
                  (edge_cnt == `SFM_FALL_EDGES - 2'h1);
wire fall_through_mode_next = fall_through_mode_take & mem_has_word;
wire fetch = std_take | fall_through_mode_first | fall_through_mode_next;
wire count_dec = std_take | fall_through_mode_take;

// write and read in one cycle cancel
wire [`SFM_CW-1:0] next_word_count = word_count + {{(`SFM_CW-1){1'b0}}, wr_take}
                                     - {{(`SFM_CW-1){1'b0}}, count_dec};
wire [`SFM_CW-1:0] next_mem_count = mem_count + {{(`SFM_CW-1){1'b0}}, drain}
                                    - {{(`SFM_CW-1){1'b0}}, fetch};

always @(posedge clk_sys) begin
  if (drain) begin
    mem[wptr] <= buf_out_data;
  end
end

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    wptr <= {`SFM_AW{1'b0}};
    rptr <= {`SFM_AW{1'b0}};
    word_count <= {`SFM_CW{1'b0}};
    mem_count <= {`SFM_CW{1'b0}};
    data_out <= {`SFM_WIDTH{1'b0}};
    fall_through_mode <= 1'b0;
  end else if (!s_reset_n) begin
    wptr <= {`SFM_AW{1'b0}};
    rptr <= {`SFM_AW{1'b0}};
    word_count <= {`SFM_CW{1'b0}};
    mem_count <= {`SFM_CW{1'b0}};
    data_out <= {`SFM_WIDTH{1'b0}};
    fall_through_mode <= (s_straps == `SFM_MODE_FALL_THROUGH_MODE);
  end else begin
    if (drain) begin
      wptr <= wptr + {{(`SFM_AW-1){1'b0}}, 1'b1};
    end
    if (fetch) begin
      data_out <= mem[rptr];
      rptr <= rptr + {{(`SFM_AW-1){1'b0}}, 1'b1};
    end
    word_count <= next_word_count;
    mem_count <= next_mem_count;
  end
end

////////////////////////////////////////////////////////////////////////////////
// fall-through output stage: the output register is the extra storage word
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    out_state <= ST_EMPTY;
    edge_cnt <= 2'h0;
  end else if (!s_reset_n || !fall_through_mode) begin
    out_state <= ST_EMPTY;
    edge_cnt <= 2'h0;
  end else begin
    case (out_state)
      ST_EMPTY: begin
        edge_cnt <= 2'h0;
        if (mem_has_word) begin
          out_state <= ST_FALL;
        end
      end
      ST_FALL: begin
        if (rd_rise) begin
          edge_cnt <= edge_cnt + 2'h1;
        end
        if (fall_through_mode_first) begin
          out_state <= ST_HOLD;
        end
      end
      ST_HOLD: begin
        edge_cnt <= 2'h0;
        if (fall_through_mode_take && !mem_has_word) begin
          out_state <= ST_EMPTY;
        end
      end
      default: begin
        out_state <= ST_EMPTY;
        edge_cnt <= 2'h0;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// status flags, registered from the occupancy; fall-through thresholds sit one word
// later because the output register counts as storage
wire [12:0] cnt_w = {4'h0, word_count};
wire [12:0] fall_through_mode_w = {12'h000, fall_through_mode};
wire [12:0] empty_ofs = {1'b0, empty_offset_set ? empty_offset : `SFM_DEF_EMPTY_OFS};
wire [12:0] full_ofs = {1'b0, full_offset_set ? full_offset : `SFM_DEF_FULL_OFS};
wire [12:0] cap_w = {4'h0, capacity};
wire [12:0] half_w = {4'h0, `SFM_HALF};
reg next_empty_flag_n;
reg next_full_flag_n;
reg next_half_full_flag_n;
reg next_almost_empty_flag_n;
reg next_almost_full_flag_n;
reg next_input_ready_n;
reg next_output_ready_n;

// each mode holds the other mode's flags inactive
always @* begin
  next_almost_empty_flag_n = reached(cnt_w, empty_ofs + 13'h0001 + fall_through_mode_w);
  next_half_full_flag_n = ~reached(cnt_w, half_w + 13'h0001 + fall_through_mode_w);
  next_almost_full_flag_n = ~reached(cnt_w + full_ofs, cap_w);
  next_empty_flag_n = 1'b1;
  next_full_flag_n = 1'b1;
  next_input_ready_n = 1'b1;
  next_output_ready_n = 1'b1;
  if (fall_through_mode) begin
    next_input_ready_n = reached(cnt_w, cap_w);
    next_output_ready_n = ~holding(out_state);
  end else begin
    next_empty_flag_n = mem_has_word;
    next_full_flag_n = ~reached(cnt_w, cap_w);
  end
end

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    empty_flag_n <= 1'b0;
    full_flag_n <= 1'b1;
    half_full_flag_n <= 1'b1;
    almost_empty_flag_n <= 1'b0;
    almost_full_flag_n <= 1'b1;
    input_ready_n <= 1'b1;
    output_ready_n <= 1'b1;
  end else begin
    empty_flag_n <= next_empty_flag_n;
    full_flag_n <= next_full_flag_n;
    half_full_flag_n <= next_half_full_flag_n;
    almost_empty_flag_n <= next_almost_empty_flag_n;
    almost_full_flag_n <= next_almost_full_flag_n;
    input_ready_n <= next_input_ready_n;
    output_ready_n <= next_output_ready_n;
  end
end

endmodule // sfm_fifo

/* sfm_fifo_sva.sv */
// concurrent checks on the fifo bank flags, mode and output data
`include "sfm_defs.vh"
module sfm_fifo_sva (
  input logic clk_sys, // system clock
  input logic rst_b, // async reset, active low
  input logic reset_in_n, // bank reset pin
  input logic [`SFM_WIDTH-1:0] data_out, // output data
  input logic empty_flag_n, // empty, active low
  input logic full_flag_n, // full, active low
  input logic half_full_flag_n, // half full, active low
  input logic input_ready_n, // fall-through input ready
  input logic output_ready_n, // fall-through output ready
  input logic fall_through_mode // selected mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  AST_STD_READY: assert property (
    !fall_through_mode && !$past(fall_through_mode) |-> input_ready_n && output_ready_n)
    else $error("ready flag active in standard mode");
  AST_FALL_THROUGH_MODE_FLAGS: assert property (
    fall_through_mode && $past(fall_through_mode) |-> empty_flag_n && full_flag_n)
    else $error("empty or full active in fall-through");
  AST_FULL_IMPL: assert property (
    !full_flag_n |-> !half_full_flag_n && empty_flag_n)
    else $error("full without half full");
  AST_EMPTY_IMPL: assert property (
    !empty_flag_n |-> half_full_flag_n && full_flag_n)
    else $error("empty with high level flags");
  // a read while empty must not disturb the output data
  AST_EMPTY_HOLD: assert property (
    !empty_flag_n && !fall_through_mode && reset_in_n |=> $stable(data_out))
    else $error("data moved while empty");
  AST_FULL_FELL: assert property (
    $fell(full_flag_n) |-> !$past(half_full_flag_n))
    else $error("full before half full");
  AST_FULL_ROSE: assert property (
    $rose(full_flag_n) && reset_in_n && $past(reset_in_n, 4) |-> !half_full_flag_n)
    else $error("first read from full lost half full");
  AST_HF_ROSE: assert property (
    $rose(half_full_flag_n) |-> full_flag_n && $past(empty_flag_n))
    else $error("half full released badly");
  AST_MODE_STABLE: assert property (
    reset_in_n [*4] |=> $stable(fall_through_mode))
    else $error("mode changed outside reset");
endmodule // sfm_fifo_sva

/* tb_top.sv */
// bench for the fifo bank: mode straps, fill and drain with flags, fall-through
`include "sfm_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic reset_in_n = 1'b0;
  logic [2:0] strap = 3'h7;
  logic [11:0] ofs_e = 12'h000;
  logic [11:0] ofs_f = 12'h000;
  logic ofs_on = 1'b0;
  logic [17:0] wdat = 18'h2A5C3;
  logic [17:0] exp_d = 18'h00000;
  logic [17:0] q[$];
  int cnt = 0;
  int n_mismatch = 0;
  int total_checks = 0;
  wire wr_clk, wr_en_n, rd_clk, rd_en_n, fall_through_mode;
  wire [17:0] wr_data, data_out;
  wire [4:0] fl; // full, almost full, half full, almost empty, empty
  wire [1:0] rdy; // input ready, output ready
  always #12.5 clk_sys = ~clk_sys;
  sfm_far far (.clk_sys(clk_sys), .wr_clk(wr_clk), .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_clk(rd_clk),
    .rd_en_n(rd_en_n));
  sfm_fifo dut (.clk_sys(clk_sys), .rst_b(rst_b), .reset_in_n(reset_in_n), .first_load_n(strap[2]),
    .read_chain_in_n(strap[1]), .write_chain_in_n(strap[0]), .wr_clk(wr_clk), .wr_en_n(wr_en_n),
    .wr_data(wr_data), .rd_clk(rd_clk), .rd_en_n(rd_en_n), .empty_offset(ofs_e), .empty_offset_set(ofs_on),
    .full_offset(ofs_f), .full_offset_set(ofs_on), .data_out(data_out), .empty_flag_n(fl[0]),
    .full_flag_n(fl[4]), .half_full_flag_n(fl[2]), .almost_empty_flag_n(fl[1]), .almost_full_flag_n(fl[3]),
    .input_ready_n(rdy[1]), .output_ready_n(rdy[0]), .fall_through_mode(fall_through_mode));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [4:0] exp_fl(int c);
    int n;
    int m;
    n = ofs_on ? int'(ofs_e) : 31;
    m = ofs_on ? int'(ofs_f) : 31;
    return {c != 256, c < 256 - m, c <= 128, c > n, c != 0};
  endfunction
  // one write and/or read slot, then outputs checked once settled
  task automatic step(input bit w, input bit r);
    int c0;
    c0 = cnt;
    far.op(w, r, wdat);
    if (w && c0 < 256) begin
      q.push_back(wdat);
      cnt++;
    end
    if (r && c0 > 0) begin
      exp_d = q.pop_front();
      cnt--;
    end
    wdat = wdat + 18'h01357;
    #60;
    chk(data_out, exp_d);
    chk(18'(fl), 18'(exp_fl(cnt)));
  endtask
  task automatic fill_drain();
    repeat (258) step(1'b1, 1'b0);
    repeat (127) step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    repeat (130) step(1'b0, 1'b1);
    $display("fill and drain done, programmed offsets %0d", ofs_on);
  endtask
  task automatic mode_rst(input logic [2:0] s);
    @(posedge clk_sys);
    reset_in_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge clk_sys);
    reset_in_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(18'(fall_through_mode), 18'(s == `SFM_MODE_FALL_THROUGH_MODE));
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    mode_rst(3'h7);
    chk(18'(fl), 18'(exp_fl(0)));
    fill_drain();
    @(posedge clk_sys);
    ofs_e <= 12'h005;
    ofs_f <= 12'h00A;
    ofs_on <= 1'b1;
    fill_drain();
    mode_rst(`SFM_MODE_FALL_THROUGH_MODE);
    far.op(1'b1, 1'b0, wdat);
    @(posedge rd_clk);
    #100;
    chk(18'(rdy[0]), 18'h00001);
    repeat (2) @(posedge rd_clk);
    #150;
    chk(data_out, wdat);
    chk(18'({rdy, fl[4], fl[0]}), 18'h00003);
    far.op(1'b0, 1'b1, wdat);
    #60;
    chk(18'(rdy), 18'h00001);
    $display("fall-through test done");
    tally_and_finish();
  end
  initial begin
    #600000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb_top
bind sfm_fifo sfm_fifo_sva chk_i (.clk_sys(clk_sys), .rst_b(rst_b), .reset_in_n(reset_in_n), .data_out(data_out),
  .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .half_full_flag_n(half_full_flag_n),
  .input_ready_n(input_ready_n), .output_ready_n(output_ready_n), .fall_through_mode(fall_through_mode));
